// >>> rtl/tppio_core.sv
// Triple eight-bit parallel port with host command and data access
//
// Summary of operation
// - Command byte 0x80..0x9B with bit 2 clear sets group directions
// - Ports A and B switch direction whole
// - Port C bits 4-7 and bits 0-3 each switch direction as a whole, independently
// - Operator instance same codes, no inverting drivers
// - Keypad rows read from port C low
// - Keypad columns are C high, B bits 0-1
// - Only keypad rows idle high when undriven
// - Newly configured outputs drive low, main instance port B high
// - Main instance port B inverted high-current drive
`timescale 1ns/100ps
module tppio_core
  import tppio_pkg::*;
#(
  parameter bit HIGH_CURRENT_B = 1'b1  // 1 main instance, 0 operator instance
) (
  input  wire logic                   clk,        // 100 MHz clock
  input  wire logic                   rst,        // Sync reset, active high
  input  wire logic                   ce,         // Clock enable
  input  wire tppio_pkg::tppio_req_t  req,        // Host access
  output logic      [7:0]             rdata,      // Read data, registered
  output logic                        rvalid,     // Read data valid pulse
  output logic                        cmd_err,    // Last command illegal
  input  wire tppio_pkg::tppio_pins_t pin_in,     // Pin levels
  output tppio_pkg::tppio_pins_t      pin_out,    // Pin drive values
  output tppio_pkg::tppio_pins_t      pin_oe_n,   // Low while driving
  output logic      [3:0]             key_row,    // Keypad rows
  output logic      [3:0]             dir_state   // Group directions a,b,chi,clo
);
  import tppio_pkg::*;

  // ==========================================================
  // Configuration
  logic [7:0]  cmd_q;
  logic        err_q;
  tppio_dir_t  dir;
  logic        cfg_wr;

  assign cfg_wr = ce && req.wr && (req.loc == TPPIO_LOC_CONFIG);

  // Illegal code keeps the old directions and raises the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= TPPIO_CMD_RST;
      err_q <= 1'b0;
    end else if (cfg_wr) begin
      if (tppio_cmd_ok(req.wdata)) begin
        cmd_q <= req.wdata;
        err_q <= 1'b0;
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  assign dir       = tppio_decode(cmd_q);
  assign dir_state = dir;
  assign cmd_err   = err_q;

  // ==========================================================
  // Output latches, cleared on every accepted command
  logic [7:0] lat_a_q, lat_b_q, lat_c_q;
  logic       cfg_ok;

  assign cfg_ok = cfg_wr && tppio_cmd_ok(req.wdata);

  // Outputs come up low after any accepted command (main port B high), so a line
  // never drives a stale level the instant it turns to output
  always_ff @(posedge clk) begin
    if (rst || cfg_ok) begin
      lat_a_q <= TPPIO_DATA_RST;
      lat_b_q <= TPPIO_DATA_RST;
      lat_c_q <= TPPIO_DATA_RST;
    end else if (ce && req.wr) begin
      unique case (req.loc)
        TPPIO_LOC_PORT_A: lat_a_q <= req.wdata;
        TPPIO_LOC_PORT_B: lat_b_q <= req.wdata;
        TPPIO_LOC_PORT_C: lat_c_q <= req.wdata;
        TPPIO_LOC_CONFIG: ;
      endcase
    end
  end

  // ==========================================================
  // Pin drive
  logic [7:0] mask_a, mask_b, mask_c;

  assign mask_a = {8{dir.a_in}};
  assign mask_b = {8{dir.b_in}};
  assign mask_c = {{4{dir.chi_in}}, {4{dir.clo_in}}};

  assign pin_out.a  = lat_a_q;
  // Main instance: a 1 in the latch switches the sink on, pin low
  assign pin_out.b  = HIGH_CURRENT_B ? ~lat_b_q : lat_b_q;
  assign pin_out.c  = lat_c_q;
  assign pin_oe_n.a = mask_a;
  assign pin_oe_n.b = mask_b;
  assign pin_oe_n.c = mask_c;

  // Keypad rows; pull-ups make idle rows read 1
  assign key_row = pin_in.c[TPPIO_ROW_LSB +: 4];

  // ==========================================================
  // Read path
  logic [7:0] rd_a, rd_b, rd_c;
  logic [7:0] pin_b_logic;

  // Port B inputs on the main instance read back as logic values
  assign pin_b_logic = HIGH_CURRENT_B ? ~pin_in.b : pin_in.b;

  tppio_readmux u_rd_a (.latch_q(lat_a_q), .pin_in(pin_in.a),   .in_mask(mask_a), .rd_val(rd_a));
  tppio_readmux u_rd_b (.latch_q(lat_b_q), .pin_in(pin_b_logic), .in_mask(mask_b), .rd_val(rd_b));
  tppio_readmux u_rd_c (.latch_q(lat_c_q), .pin_in(pin_in.c),   .in_mask(mask_c), .rd_val(rd_c));

  // Read data held until the next read; rvalid marks it for one edge
  // Reset is not gated by ce, so a frozen block can still be cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata  <= TPPIO_DATA_RST;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd;
      if (req.rd) begin
        unique case (req.loc)
          TPPIO_LOC_PORT_A: rdata <= rd_a;
          TPPIO_LOC_PORT_B: rdata <= rd_b;
          TPPIO_LOC_PORT_C: rdata <= rd_c;
          TPPIO_LOC_CONFIG: rdata <= cmd_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks: command and direction
  clear_on_cfg_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ok |=> (lat_a_q == 8'h00 && lat_b_q == 8'h00 && lat_c_q == 8'h00))
    else $error("latches not cleared by command");

  cmd_legal_a: assert property (@(posedge clk) disable iff (rst)
    cfg_wr && !tppio_cmd_ok(req.wdata) |=> $stable(cmd_q) && err_q)
    else $error("illegal command accepted");

  cmd_take_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ok |=> cmd_q == $past(req.wdata))
    else $error("legal command not stored");

  port_ab_dir_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ok |=> pin_oe_n.a == {8{$past(req.wdata[TPPIO_CMD_A_BIT])}}
               && pin_oe_n.b == {8{$past(req.wdata[TPPIO_CMD_B_BIT])}})
    else $error("port a or b direction wrong");

  err_clear_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ok |=> !cmd_err)
    else $error("error flag not cleared by legal command");

  cmd_hold_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_ok |=> $stable(cmd_q))
    else $error("command changed without legal write");

  // Clock enable low freezes every register
  ce_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(cmd_q) && $stable(err_q) && $stable(lat_a_q) && $stable(lat_b_q)
            && $stable(lat_c_q) && $stable(rdata) && $stable(rvalid))
    else $error("state moved while clock enable low");

  // ==========================================================
  // Checks: pin drive
  write_a_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.wr && req.loc == TPPIO_LOC_PORT_A
    |=> pin_out.a == $past(req.wdata))
    else $error("port a drive mismatch");

  write_c_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.wr && req.loc == TPPIO_LOC_PORT_C
    |=> pin_out.c == $past(req.wdata))
    else $error("port c drive mismatch");

  hc_invert_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.wr && req.loc == TPPIO_LOC_PORT_B
    |=> pin_out.b == (HIGH_CURRENT_B ? ~$past(req.wdata) : $past(req.wdata)))
    else $error("port b drive polarity wrong");

  port_a_whole_a: assert property (@(posedge clk) disable iff (rst)
    pin_oe_n.a == 8'h00 || pin_oe_n.a == 8'hFF)
    else $error("port a split direction");

  nibble_dir_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ok |=> pin_oe_n.c[7:4] == {4{$past(req.wdata[3])}}
               && pin_oe_n.c[3:0] == {4{$past(req.wdata[0])}})
    else $error("port c nibble direction wrong");

  // ==========================================================
  // Checks: read answers
  rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ce && !req.rd |=> !rvalid)
    else $error("read valid without read");

  read_c_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.loc == TPPIO_LOC_PORT_C && dir.clo_in
    |=> rvalid && rdata[3:0] == $past(pin_in.c[3:0]))
    else $error("row read mismatch");

  read_out_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.loc == TPPIO_LOC_PORT_A && !dir.a_in
    |=> rdata == $past(lat_a_q))
    else $error("output read-back mismatch");

  read_a_in_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.loc == TPPIO_LOC_PORT_A && dir.a_in
    |=> rdata == $past(pin_in.a))
    else $error("port a input read mismatch");

  read_b_in_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.loc == TPPIO_LOC_PORT_B && dir.b_in
    |=> rdata == (HIGH_CURRENT_B ? ~$past(pin_in.b) : $past(pin_in.b)))
    else $error("port b input read mismatch");

  read_cfg_a: assert property (@(posedge clk) disable iff (rst)
    ce && req.rd && req.loc == TPPIO_LOC_CONFIG
    |=> rdata == $past(cmd_q))
    else $error("command read-back mismatch");

endmodule // tppio_core

// >>> rtl/tppio_pkg.sv
// Package with constants and types for the triple parallel port block
package tppio_pkg;

  // ==========================================================
  // Host access locations (address bits 2:1 of the byte address)
  localparam logic [1:0] TPPIO_LOC_PORT_A = 2'h0;
  localparam logic [1:0] TPPIO_LOC_PORT_B = 2'h1;
  localparam logic [1:0] TPPIO_LOC_PORT_C = 2'h2;
  localparam logic [1:0] TPPIO_LOC_CONFIG = 2'h3;

  // ==========================================================
  // Command byte fields
  localparam int         TPPIO_CMD_FLAG_BIT  = 7;
  localparam int         TPPIO_CMD_A_BIT     = 4;
  localparam int         TPPIO_CMD_CHI_BIT   = 3;
  localparam int         TPPIO_CMD_B_BIT     = 1;
  localparam int         TPPIO_CMD_CLO_BIT   = 0;
  localparam logic [7:0] TPPIO_CMD_MODE_MASK = 8'h64;
  localparam logic [7:0] TPPIO_CMD_FIRST     = 8'h80;
  localparam logic [7:0] TPPIO_CMD_LAST      = 8'h9B;

  // ==========================================================
  // Reset values: all groups input, outputs latched low
  localparam logic [7:0] TPPIO_DATA_RST  = 8'h00;
  localparam logic [7:0] TPPIO_CMD_RST   = 8'h9B;

  // Keypad line positions
  localparam int         TPPIO_ROW_LSB   = 0;
  localparam int         TPPIO_COL_LSB   = 4;

  // ==========================================================
  // Direction of the four groups, 1 = input
  typedef struct packed {
    logic a_in;
    logic b_in;
    logic chi_in;
    logic clo_in;
  } tppio_dir_t;

  // Host access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] loc;
    logic [7:0] wdata;
  } tppio_req_t;

  // Port pin bundle
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } tppio_pins_t;

  // Decode a command byte into group directions
  function automatic tppio_dir_t tppio_decode(input logic [7:0] cmd);
    tppio_dir_t d;
    d.a_in   = cmd[TPPIO_CMD_A_BIT];
    d.b_in   = cmd[TPPIO_CMD_B_BIT];
    d.chi_in = cmd[TPPIO_CMD_CHI_BIT];
    d.clo_in = cmd[TPPIO_CMD_CLO_BIT];
    return d;
  endfunction

  // Legal command: flag set, mode bits clear, in range
  function automatic logic tppio_cmd_ok(input logic [7:0] cmd);
    return cmd[TPPIO_CMD_FLAG_BIT] && ((cmd & TPPIO_CMD_MODE_MASK) == 8'h00)
           && (cmd >= TPPIO_CMD_FIRST) && (cmd <= TPPIO_CMD_LAST);
  endfunction

endpackage

// >>> rtl/tppio_readmux.sv
// Read-back mixer: pin level for inputs, latch for outputs
`timescale 1ns/100ps
module tppio_readmux (
  input  wire logic [7:0] latch_q,   // Written output value
  input  wire logic [7:0] pin_in,    // Sampled pin level
  input  wire logic [7:0] in_mask,   // 1 where line is input
  output logic      [7:0] rd_val     // Value seen by host
);
  assign rd_val = (pin_in & in_mask) | (latch_q & ~in_mask);
endmodule // tppio_readmux

// >>> testbench/tppio_pins_model.sv
// Pin-side model: external drivers and keypad row pull-ups
`timescale 1ns/100ps
module tppio_pins_model
  import tppio_pkg::*;
(
  input  wire logic                   clk,      // Clock
  input  wire tppio_pkg::tppio_pins_t pin_out,  // Block drive
  input  wire tppio_pkg::tppio_pins_t pin_oe_n, // Low while driving
  input  wire tppio_pkg::tppio_pins_t ext,      // External level
  input  wire tppio_pkg::tppio_pins_t ext_en,   // External drives
  output tppio_pkg::tppio_pins_t      pin_in    // Wire level
);
  import tppio_pkg::*;
  logic [23:0] flip_q = 24'h000000;
  always_ff @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext[i];
      else if (i < 4) pin_in[i] = 1'b1;
      else pin_in[i] = flip_q[i];
    end
  end
endmodule // tppio_pins_model

// >>> testbench/test_triple_parallel_port_io.sv
// Self-checking bench for the triple parallel port block
`timescale 1ns/100ps
module test_triple_parallel_port_io;
  import tppio_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  tppio_req_t  req = '0;
  tppio_pins_t ext = '0;
  tppio_pins_t ext_en = '0;
  tppio_pins_t pin_in, pin_out, pin_oe_n, op_out;
  logic [7:0]  rdata, c;
  logic        rvalid, cmd_err;
  logic [3:0]  key_row, dir_state;
  int          bad_count = 0;
  int          check_count = 0;
  // Host byte addresses; bits 2:1 select the location
  localparam logic [27:0] MAIN_CFG_ADDR  = 28'h6000006;
  localparam logic [27:0] OP_PORT_C_ADDR = 28'h6000184;
  localparam logic [27:0] OP_CFG_ADDR    = 28'h6000186;
  always #5 clk = ~clk;
  tppio_core #(.HIGH_CURRENT_B(1'b1)) u_dut (.clk(clk), .rst(rst), .ce(ce),
    .req(req), .rdata(rdata), .rvalid(rvalid), .cmd_err(cmd_err), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .key_row(key_row), .dir_state(dir_state));
  tppio_core #(.HIGH_CURRENT_B(1'b0)) u_op (.clk(clk), .rst(rst), .ce(ce),
    .req(req), .rdata(), .rvalid(), .cmd_err(), .pin_in(pin_in),
    .pin_out(op_out), .pin_oe_n(), .key_row(), .dir_state());
  tppio_pins_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic rd, input logic [1:0] loc, input logic [7:0] d);
    @(negedge clk);
    req = '{rd: rd, wr: !rd, loc: loc, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd_chk(input logic [1:0] loc, input logic [7:0] exp);
    acc(1'b1, loc, 8'h00);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({4'h0, dir_state}, 8'h0F);
    chk(pin_out.b, 8'hFF);
    rd_chk(TPPIO_LOC_CONFIG, TPPIO_CMD_RST);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      c = 8'h80 | i[7:0];
      if (c[2]) continue;
      acc(1'b0, TPPIO_LOC_PORT_A, 8'hFF);
      acc(1'b0, MAIN_CFG_ADDR[2:1], c);
      chk({7'h00, cmd_err}, 8'h00);
      chk({4'h0, dir_state}, {4'h0, c[4], c[1], c[3], c[0]});
      chk(pin_oe_n.a, {8{c[4]}});
      chk(pin_oe_n.b, {8{c[1]}});
      chk(pin_oe_n.c, {{4{c[3]}}, {4{c[0]}}});
      chk(pin_out.a, 8'h00);
    end
    $display("test command codes done");
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h80);
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h84);
    chk({7'h00, cmd_err}, 8'h01);
    chk({4'h0, dir_state}, 8'h00);
    acc(1'b0, TPPIO_LOC_PORT_A, 8'h5A);
    rd_chk(TPPIO_LOC_PORT_A, 8'h5A);
    acc(1'b0, TPPIO_LOC_PORT_B, 8'h03);
    chk(pin_out.b, 8'hFC);
    chk(op_out.b, 8'h03);
    rd_chk(TPPIO_LOC_PORT_B, 8'h03);
    $display("test outputs done");
    acc(1'b0, OP_CFG_ADDR[2:1], 8'h81);
    chk({7'h00, cmd_err}, 8'h00);
    acc(1'b0, OP_PORT_C_ADDR[2:1], 8'hA0);
    ext_en.c = 8'h05;
    #1;
    chk({4'h0, pin_out.c[7:4]}, 8'h0A);
    chk({4'h0, key_row}, 8'h0A);
    rd_chk(OP_PORT_C_ADDR[2:1], 8'hAA);
    $display("test keypad done");
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h9B);
    ext = '{a: 8'h5A, b: 8'h3C, c: 8'h00};
    ext_en = '1;
    rd_chk(TPPIO_LOC_PORT_A, 8'h5A);
    rd_chk(TPPIO_LOC_PORT_B, 8'hC3);
    ce = 1'b0;
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h80);
    ce = 1'b1;
    chk({4'h0, dir_state}, 8'h0F);
    $display("test inputs done");
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h80);
    acc(1'b0, TPPIO_LOC_PORT_A, 8'h5A);
    acc(1'b0, TPPIO_LOC_CONFIG, 8'h84);
    chk({7'h00, cmd_err}, 8'h01);
    chk(pin_out.a, 8'h5A);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({4'h0, dir_state}, 8'h0F);
    chk(pin_out.a, TPPIO_DATA_RST);
    chk({7'h00, cmd_err}, 8'h00);
    rd_chk(TPPIO_LOC_CONFIG, TPPIO_CMD_RST);
    $display("test mid-run reset done");
    report_and_stop();
  end
  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
endmodule // test_triple_parallel_port_io
